// ---- src/uhcr_pkg.sv ----
// Overview of operation
// - decode 000h-0FCh test area, 100h-124h capability, 140h-1FCh operational space.
// - writes to read-only registers or bits leave contents unchanged.
// - reads of write-only registers return all zeros.
// - write-one-to-clear bits clear on 1, hold on 0, read current value.
// - bit 0 is most significant; no endianness conversion anywhere.
// - capability region length reads constant 40h.
// - length sits in byte 0, version in bytes 2-3 for narrow reads.
// - version is read-only BCD, major in 16-23, minor 24-31, 8-15 zero.
// - debug port number field reads constant zero.
// - port indicator bit reflects build option, default 1, read-only.
// - companion count, ports per companion and routing rules read zero.
// - port power bit reflects build option, default 1, read-only.
// - port count field reads constant 1.
// - extended capabilities pointer reads zero.
// - isochronous scheduling threshold reads binary 1000.
// - asynchronous schedule parking support bit reads 1.
// - programmable frame list bit reads 1.
// - 64-bit addressing bit reads 0; bits 0-15 and 28 read zero.
// - companion route table is not implemented; its offsets read zero.
// - port power option 0 means no power control, 1 means provided.
package uhcr_pkg;

  // bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // address space partition
  localparam logic [8:0] TEST_LO = 9'h000;
  localparam logic [8:0] TEST_HI = 9'h0fc;
  localparam logic [8:0] CAP_LO  = 9'h100;
  localparam logic [8:0] CAP_HI  = 9'h124;
  localparam logic [8:0] OP_LO   = 9'h140;
  localparam logic [8:0] OP_HI   = 9'h1fc;

  // capability register offsets from the capability base
  localparam logic [8:0] LEN_VER_OFS = 9'h000;
  localparam logic [8:0] STRUCT_OFS  = 9'h004;
  localparam logic [8:0] CAPPAR_OFS  = 9'h008;
  localparam logic [8:0] ROUTE_OFS   = 9'h00c;

  // test area registers
  localparam logic [8:0] SCRATCH_OFS = 9'h000;
  localparam logic [8:0] WONLY_OFS   = 9'h004;
  localparam logic [8:0] EVENT_OFS   = 9'h008;
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] WONLY_RST   = 32'h0000_0000;
  localparam logic [31:0] EVENT_RST   = 32'h0000_0000;

  // length/version fields, msb-first numbering mapped to [31:0]
  localparam logic [7:0] CAP_LEN_VAL = 8'h40;
  localparam int LEN_POS = 24;
  localparam int VMAJ_POS = 8;
  localparam int VMIN_POS = 0;

  // structural parameter fields
  localparam int PIND_POS = 16;
  localparam int PPWR_POS = 4;
  localparam int NPORT_POS = 0;
  localparam logic [3:0] NPORT_VAL = 4'h1;
  localparam logic [3:0] DBG_PORT_VAL = 4'h0;
  localparam int DBG_PORT_POS = 20;

  // capability parameter fields
  localparam int IST_POS = 4;
  localparam logic [3:0] IST_VAL = 4'h8;
  localparam int PARK_POS = 2;
  localparam int PFL_POS = 1;
  localparam int ADDR64_POS = 0;

  // access types of a register cell
  typedef enum logic [1:0] {
    UHCR_RO  = 2'h0,
    UHCR_WO  = 2'h1,
    UHCR_RW  = 2'h2,
    UHCR_W1C = 2'h3
  } uhcr_access_type;

  // request from the processor slave port
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] wdata;
  } uhcr_req_type;

endpackage

// ---- src/uhcr_access_cell.sv ----
`timescale 1ns/1ps
// one register word with selectable access type
module uhcr_access_cell #(
  parameter uhcr_pkg::uhcr_access_type ACCESS = uhcr_pkg::UHCR_RW,
  parameter logic [31:0]               RESET  = 32'h0000_0000
) (
  // clock and control
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // write side
  input  wire logic        wr_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [31:0] set_in,
  // read side
  output logic      [31:0] value_out,
  output logic      [31:0] rdata_out
);

  typedef struct packed {
    logic [31:0] value;
  } uhcr_cell_type;

  uhcr_cell_type state_ff;
  uhcr_cell_type nxt_state;
  logic [31:0]   lane_mask;

  // byte enables widened to a bit mask
  always_comb begin
    lane_mask = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}}, {8{be_in[0]}}};
  end

  // next value by access type
  always_comb begin
    nxt_state = state_ff;
    case (ACCESS)
      uhcr_pkg::UHCR_RO: begin
        nxt_state.value = state_ff.value;
      end
      uhcr_pkg::UHCR_W1C: begin
        // a hardware set in the clearing cycle wins
        if (wr_in) begin
          nxt_state.value = state_ff.value & ~(wdata_in & lane_mask);
        end
        nxt_state.value = nxt_state.value | set_in;
      end
      default: begin
        if (wr_in) begin
          nxt_state.value = (state_ff.value & ~lane_mask)
                          | (wdata_in & lane_mask);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff <= '{value: RESET};
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // read view
  assign value_out = state_ff.value;
  assign rdata_out = (ACCESS == uhcr_pkg::UHCR_WO) ? 32'h0000_0000
                                                    : state_ff.value;

endmodule

// ---- src/uhcr_regs.sv ----
`timescale 1ns/1ps
// register module front end: partition decode, capability registers,
// test area cells and forwarding into the operational register block
module uhcr_regs #(
  parameter logic       PORT_INDICATOR_OPT = 1'b1,
  parameter logic       PORT_POWER_OPT     = 1'b1,
  parameter logic [7:0] VERSION_MAJOR      = 8'h09, // arbitrary value
  parameter logic [7:0] VERSION_MINOR      = 8'h09  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // processor slave port
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [8:0]  addr_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out,
  output logic             busy_out,
  // operational register block
  output logic             op_req_out,
  output logic             op_wr_out,
  output logic      [7:0]  op_addr_out,
  output logic      [3:0]  op_be_out,
  output logic      [31:0] op_wdata_out,
  input  wire logic        op_ack_in,
  input  wire logic [31:0] op_rdata_in,
  // test area hooks
  input  wire logic [31:0] test_event_in,
  output logic      [31:0] test_scratch_out,
  output logic      [31:0] test_wonly_out
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_OPWAIT = 2'b10
  } uhcr_state_type;

  typedef struct packed {
    uhcr_state_type st;
    logic           ack;
    logic [31:0]    rdata;
    logic           op_req;
    logic           op_wr;
    logic [7:0]     op_addr;
    logic [3:0]     op_be;
    logic [31:0]    op_wdata;
    logic [31:0]    scratch;
    logic [31:0]    wonly;
  } uhcr_regs_type;

  uhcr_regs_type          state_ff;
  uhcr_regs_type          nxt_state;
  uhcr_pkg::uhcr_req_type req;

  logic [8:0]  word_addr;
  logic [8:0]  cap_ofs;
  logic [8:0]  test_ofs;
  logic        in_test;
  logic        in_cap;
  logic        in_op;
  logic [31:0] len_ver_word;
  logic [31:0] struct_word;
  logic [31:0] cappar_word;
  logic [31:0] cap_rdata;
  logic [31:0] test_rdata;
  logic        scr_wr;
  logic        wo_wr;
  logic        ev_wr;
  logic [31:0] scr_val;
  logic [31:0] scr_rd;
  logic [31:0] wo_val;
  logic [31:0] wo_rd;
  logic [31:0] ev_rd;

  // gather the request
  always_comb begin
    req.wr    = wr_in;
    req.addr  = addr_in;
    req.be    = be_in;
    req.wdata = wdata_in;
  end

  // partition decode on word addresses
  always_comb begin
    word_addr = {req.addr[8:2], 2'b00};
    cap_ofs   = word_addr - uhcr_pkg::CAP_LO;
    test_ofs  = word_addr - uhcr_pkg::TEST_LO;
    in_test   = 1'b0;
    in_cap    = 1'b0;
    in_op     = 1'b0;
    if (word_addr <= uhcr_pkg::TEST_HI) begin
      in_test = 1'b1;
    end else if (word_addr >= uhcr_pkg::CAP_LO &&
                 word_addr <= uhcr_pkg::CAP_HI) begin
      in_cap = 1'b1;
    end else if (word_addr >= uhcr_pkg::OP_LO &&
                 word_addr <= uhcr_pkg::OP_HI) begin
      in_op = 1'b1;
    end
  end

  // length and version word, bytes placed for narrow big-endian reads
  always_comb begin
    len_ver_word = 32'h0000_0000;
    len_ver_word[uhcr_pkg::LEN_POS +: 8]  = uhcr_pkg::CAP_LEN_VAL;
    len_ver_word[uhcr_pkg::VMAJ_POS +: 8] = VERSION_MAJOR;
    len_ver_word[uhcr_pkg::VMIN_POS +: 8] = VERSION_MINOR;
  end

  // structural parameters, build options fixed at elaboration
  always_comb begin
    struct_word = 32'h0000_0000;
    struct_word[uhcr_pkg::DBG_PORT_POS +: 4] = uhcr_pkg::DBG_PORT_VAL;
    struct_word[uhcr_pkg::PIND_POS]  = PORT_INDICATOR_OPT;
    struct_word[uhcr_pkg::PPWR_POS]  = PORT_POWER_OPT;
    struct_word[uhcr_pkg::NPORT_POS +: 4] = uhcr_pkg::NPORT_VAL;
  end

  // capability parameters
  always_comb begin
    cappar_word = 32'h0000_0000;
    cappar_word[uhcr_pkg::IST_POS +: 4] = uhcr_pkg::IST_VAL;
    cappar_word[uhcr_pkg::PARK_POS]     = 1'b1;
    cappar_word[uhcr_pkg::PFL_POS]      = 1'b1;
    cappar_word[uhcr_pkg::ADDR64_POS]   = 1'b0;
  end

  // capability read mux; route table and gaps read zero
  always_comb begin
    if (cap_ofs == uhcr_pkg::LEN_VER_OFS) begin
      cap_rdata = len_ver_word;
    end else if (cap_ofs == uhcr_pkg::STRUCT_OFS) begin
      cap_rdata = struct_word;
    end else if (cap_ofs == uhcr_pkg::CAPPAR_OFS) begin
      cap_rdata = cappar_word;
    end else begin
      cap_rdata = 32'h0000_0000;
    end
  end

  // test area write strobes
  always_comb begin
    scr_wr = 1'b0;
    wo_wr  = 1'b0;
    ev_wr  = 1'b0;
    if (req_in && req.wr && in_test && state_ff.st == ST_IDLE) begin
      if (test_ofs == uhcr_pkg::SCRATCH_OFS) begin
        scr_wr = 1'b1;
      end else if (test_ofs == uhcr_pkg::WONLY_OFS) begin
        wo_wr = 1'b1;
      end else if (test_ofs == uhcr_pkg::EVENT_OFS) begin
        ev_wr = 1'b1;
      end
    end
  end

  // read/write scratch word
  uhcr_access_cell #(
    .ACCESS (uhcr_pkg::UHCR_RW),
    .RESET  (uhcr_pkg::SCRATCH_RST)
  ) u_scratch (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .wr_in      (scr_wr),
    .be_in      (req.be),
    .wdata_in   (req.wdata),
    .set_in     (32'h0000_0000),
    .value_out  (scr_val),
    .rdata_out  (scr_rd)
  );

  // write-only word
  uhcr_access_cell #(
    .ACCESS (uhcr_pkg::UHCR_WO),
    .RESET  (uhcr_pkg::WONLY_RST)
  ) u_wonly (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .wr_in      (wo_wr),
    .be_in      (req.be),
    .wdata_in   (req.wdata),
    .set_in     (32'h0000_0000),
    .value_out  (wo_val),
    .rdata_out  (wo_rd)
  );

  // write-one-to-clear event word
  uhcr_access_cell #(
    .ACCESS (uhcr_pkg::UHCR_W1C),
    .RESET  (uhcr_pkg::EVENT_RST)
  ) u_event (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .wr_in      (ev_wr),
    .be_in      (req.be),
    .wdata_in   (req.wdata),
    .set_in     (test_event_in),
    .value_out  (),
    .rdata_out  (ev_rd)
  );

  // test area read mux
  always_comb begin
    if (test_ofs == uhcr_pkg::SCRATCH_OFS) begin
      test_rdata = scr_rd;
    end else if (test_ofs == uhcr_pkg::WONLY_OFS) begin
      test_rdata = wo_rd;
    end else if (test_ofs == uhcr_pkg::EVENT_OFS) begin
      test_rdata = ev_rd;
    end else begin
      test_rdata = 32'h0000_0000;
    end
  end

  // request sequencing
  always_comb begin
    nxt_state         = state_ff;
    nxt_state.ack     = 1'b0;
    nxt_state.op_req  = 1'b0;
    nxt_state.scratch = scr_val;
    nxt_state.wonly   = wo_val;
    case (state_ff.st)
      ST_IDLE: begin
        if (req_in) begin
          if (in_op) begin
            // forward word offset within operational space
            nxt_state.op_req   = 1'b1;
            nxt_state.op_wr    = req.wr;
            nxt_state.op_addr  = 8'(word_addr - uhcr_pkg::OP_LO);
            nxt_state.op_be    = req.be;
            nxt_state.op_wdata = req.wdata;
            nxt_state.st       = ST_OPWAIT;
          end else begin
            // capability writes are dropped, data passes unswapped
            nxt_state.ack   = 1'b1;
            nxt_state.rdata = 32'h0000_0000;
            if (!req.wr && in_cap) begin
              nxt_state.rdata = cap_rdata;
            end else if (!req.wr && in_test) begin
              nxt_state.rdata = test_rdata;
            end
          end
        end
      end
      ST_OPWAIT: begin
        if (op_ack_in) begin
          nxt_state.ack   = 1'b1;
          nxt_state.rdata = state_ff.op_wr ? 32'h0000_0000 : op_rdata_in;
          nxt_state.st    = ST_IDLE;
        end
      end
      default: begin
        nxt_state.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff <= '{st: ST_IDLE, ack: 1'b0, rdata: 32'h0000_0000,
                    op_req: 1'b0, op_wr: 1'b0, op_addr: 8'h00,
                    op_be: 4'h0, op_wdata: 32'h0000_0000,
                    scratch: uhcr_pkg::SCRATCH_RST,
                    wonly: uhcr_pkg::WONLY_RST};
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // registered outputs
  assign ack_out          = state_ff.ack;
  assign rdata_out        = state_ff.rdata;
  assign busy_out         = state_ff.st == ST_OPWAIT;
  assign op_req_out       = state_ff.op_req;
  assign op_wr_out        = state_ff.op_wr;
  assign op_addr_out      = state_ff.op_addr;
  assign op_be_out        = state_ff.op_be;
  assign op_wdata_out     = state_ff.op_wdata;
  assign test_scratch_out = state_ff.scratch;
  assign test_wonly_out   = state_ff.wonly;

endmodule

// ---- test/uhcr_regs_props.sv ----
`timescale 1ns/1ps
// timing and content checks on the register front end ports
module uhcr_regs_props #(
  parameter logic       PORT_INDICATOR_OPT = 1'b1,
  parameter logic       PORT_POWER_OPT     = 1'b1,
  parameter logic [7:0] VERSION_MAJOR      = 8'h09,
  parameter logic [7:0] VERSION_MINOR      = 8'h09
) (
  // clock and control
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  // slave port
  input wire logic        req_in,
  input wire logic        wr_in,
  input wire logic [8:0]  addr_in,
  input wire logic        ack_out,
  input wire logic [31:0] rdata_out,
  input wire logic        busy_out,
  // operational side
  input wire logic        op_req_out,
  input wire logic [7:0]  op_addr_out,
  input wire logic        op_ack_in
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // accepted access and read word helpers
  logic       take;
  logic       rd;
  logic [6:0] w;
  assign take = ce_in & req_in & ~busy_out;
  assign rd   = take & ~wr_in;
  assign w    = addr_in[8:2];

  property p_ack_fast;
    take && addr_in < uhcr_pkg::OP_LO |=> ack_out && !busy_out;
  endproperty
  a_ack_fast: assert property (p_ack_fast)
    else $error("local access not answered next cycle");
  property p_op_fwd;
    take && addr_in >= uhcr_pkg::OP_LO |=> op_req_out && busy_out &&
      ({1'b0, op_addr_out} + uhcr_pkg::OP_LO) == $past(addr_in);
  endproperty
  a_op_fwd: assert property (p_op_fwd)
    else $error("operational access not forwarded");
  property p_op_done;
    busy_out && op_ack_in |=> ack_out && !busy_out;
  endproperty
  a_op_done: assert property (p_op_done)
    else $error("operational answer not returned");
  property p_hold;
    busy_out && !op_ack_in |=> !ack_out && busy_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer while operational block pending");
  property p_len;
    rd && w == 7'h40 |=> rdata_out[31:16] == 16'h4000;
  endproperty
  a_len: assert property (p_len)
    else $error("region length byte wrong");
  property p_ver;
    rd && w == 7'h40 |=> rdata_out[15:0] == {VERSION_MAJOR, VERSION_MINOR};
  endproperty
  a_ver: assert property (p_ver)
    else $error("version halfword wrong");
  property p_struct;
    rd && w == 7'h41 |=> rdata_out ==
      {15'h0, PORT_INDICATOR_OPT, 11'h0, PORT_POWER_OPT, 4'h1};
  endproperty
  a_struct: assert property (p_struct)
    else $error("structural parameters wrong");
  property p_cappar;
    rd && w == 7'h42 |=> rdata_out == 32'h0000_0086;
  endproperty
  a_cappar: assert property (p_cappar)
    else $error("capability parameters wrong");
  property p_route;
    rd && w > 7'h42 && w < 7'h50 |=> rdata_out == 32'h0;
  endproperty
  a_route: assert property (p_route)
    else $error("route area not zero");
  property p_wonly;
    rd && w == 7'h01 |=> rdata_out == 32'h0;
  endproperty
  a_wonly: assert property (p_wonly)
    else $error("write-only word not read as zero");
endmodule

// ---- test/uhcr_op_model.sv ----
`timescale 1ns/1ps
// operational register block stand-in with adjustable answer delay
module uhcr_op_model (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // request side
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  dly_in,
  // answer side
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem [64];
  logic [3:0]  cnt_ff;
  logic        pend_ff;
  // capture, wait dly_in cycles, answer once
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
      ack_out <= 1'b0;
      rdata_out <= 32'h0;
    end else if (req_in) begin
      pend_ff <= 1'b1;
      cnt_ff <= dly_in;
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // data only valid with the answer
      for (int i = 0; i < 4; i++)
        if (wr_in && be_in[i]) mem[addr_in[7:2]][8*i +: 8] <= wdata_in[8*i +: 8];
    end else if (pend_ff && cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end else if (pend_ff) begin
      pend_ff <= 1'b0;
      ack_out <= 1'b1;
      rdata_out <= mem[addr_in[7:2]];
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
// front end bench: driver notes expectations, monitor compares answers
module tb;
  localparam logic       PI  = 1'b1;
  localparam logic       PP  = 1'b0;
  localparam logic [7:0] MAJ = 8'h12; // arbitrary value
  localparam logic [7:0] MIN = 8'h34; // arbitrary value
  logic        clk_sys_in, rst_in, ce_in, req, wr, ack, busy;
  logic        op_req, op_wr, op_ack;
  logic [8:0]  addr;
  logic [7:0]  op_addr;
  logic [3:0]  be, op_be, dly, b;
  logic [31:0] wdata, rdata, op_wdata, op_rdata, ev, scr, wo, sc, d;
  logic [31:0] capv [3];
  logic [31:0] shd [64];
  logic [31:0] exp_q [$];
  logic [44:0] opq [$];
  logic [44:0] o;
  int          error_cnt, total_checks, k;

  // clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  uhcr_regs #(.PORT_INDICATOR_OPT(PI), .PORT_POWER_OPT(PP),
    .VERSION_MAJOR(MAJ), .VERSION_MINOR(MIN)) uhcr_regs_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
    .wr_in(wr), .addr_in(addr), .be_in(be), .wdata_in(wdata),
    .ack_out(ack), .rdata_out(rdata), .busy_out(busy), .op_req_out(op_req),
    .op_wr_out(op_wr), .op_addr_out(op_addr), .op_be_out(op_be),
    .op_wdata_out(op_wdata), .op_ack_in(op_ack), .op_rdata_in(op_rdata),
    .test_event_in(ev), .test_scratch_out(scr), .test_wonly_out(wo));
  uhcr_op_model uhcr_op_model_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .req_in(op_req), .wr_in(op_wr), .addr_in(op_addr),
    .be_in(op_be), .wdata_in(op_wdata), .dly_in(dly), .ack_out(op_ack),
    .rdata_out(op_rdata));

  task automatic chk_rd(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_op(input logic [44:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR op_request exp %h got %h", e, g);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one access; hold keeps the strobe up for a back-to-back follower
  task automatic acc(input logic w, input logic [8:0] a,
    input logic [3:0] bb, input logic [31:0] dd, e, input bit hold);
    int n;
    exp_q.push_back(e);
    if (a >= uhcr_pkg::OP_LO)
      opq.push_back({w, 8'(a - uhcr_pkg::OP_LO), bb, dd});
    req <= 1'b1;
    wr <= w;
    addr <= a;
    be <= bb;
    wdata <= dd;
    @(posedge clk_sys_in);
    if (!hold) begin
      req <= 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 40) begin
        @(posedge clk_sys_in);
        n++;
      end
      if (n == 40) begin
        error_cnt++;
        final_report();
      end
    end
  endtask

  // compare answers and forwarded requests against the oldest note
  always @(posedge clk_sys_in) begin
    if (ack && exp_q.size() == 0) begin
      error_cnt++;
      $display("ERROR ack exp none got %h", rdata);
    end else if (ack) begin
      chk_rd("rdata", exp_q.pop_front(), rdata);
    end
    if (op_req) begin
      o = opq.pop_front();
      if (!o[44]) o[35:0] = 36'h0;
      chk_op(o, {op_wr, op_addr, op_wr ? {op_be, op_wdata} : 36'h0});
    end
  end

  initial begin
    {rst_in, ce_in, req, wr, addr, be, wdata, ev, dly} = {2'b11, 83'h0};
    capv = '{{8'h40, 8'h00, MAJ, MIN}, {15'h0, PI, 11'h0, PP, 4'h1},
      32'h0000_0086};
    k = $urandom(39);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    // capability words back to back, narrow lanes still full word
    acc(1'b0, 9'h100, 4'h8, 0, capv[0], 1);
    acc(1'b0, 9'h102, 4'h3, 0, capv[0], 1);
    acc(1'b0, 9'h104, 4'hf, 0, capv[1], 1);
    acc(1'b0, 9'h108, 4'hf, 0, capv[2], 1);
    for (int a = 'h10c; a < 'h140; a += 4)
      acc(1'b0, 9'(a), 4'hf, 0, 0, a != 'h13c);
    // writes to read-only words change nothing
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 9'(9'h100 + 4 * i), 4'hf, $urandom, 0, 0);
      acc(1'b0, 9'(9'h100 + 4 * i), 4'hf, 0, capv[i], 0);
    end
    $display("capability test done");
    // scratch lanes, write-only word, unmapped offset
    sc = $urandom;
    acc(1'b1, 9'h000, 4'hf, sc, 0, 0);
    b = 4'($urandom);
    d = $urandom;
    acc(1'b1, 9'h000, b, d, 0, 0);
    for (int i = 0; i < 4; i++)
      if (b[i]) sc[8*i +: 8] = d[8*i +: 8];
    acc(1'b0, 9'h000, 4'hf, 0, sc, 0);
    chk_rd("scratch", sc, scr);
    // enable low freezes all state: a standing write is not taken
    ce_in <= 1'b0;
    req <= 1'b1;
    wr <= 1'b1;
    addr <= 9'h000;
    wdata <= ~sc;
    repeat (3) @(posedge clk_sys_in);
    req <= 1'b0;
    ce_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk_rd("scratch_frozen", sc, scr);
    acc(1'b1, 9'h004, 4'hf, d, 0, 0);
    acc(1'b0, 9'h004, 4'hf, 0, 0, 0);
    chk_rd("wonly", d, wo);
    acc(1'b1, 9'h0fc, 4'hf, d, 0, 0);
    acc(1'b0, 9'h0fc, 4'hf, 0, 0, 0);
    // sticky events: write one clears, write zero keeps
    ev <= d;
    @(posedge clk_sys_in);
    ev <= 32'h0;
    @(posedge clk_sys_in);
    acc(1'b0, 9'h008, 4'hf, 0, d, 0);
    acc(1'b1, 9'h008, 4'hf, sc, 0, 0);
    acc(1'b0, 9'h008, 4'hf, 0, d & ~sc, 0);
    $display("test area done");
    // operational words with varied answer delays
    for (int i = 0; i < 24; i++) begin
      k = $urandom_range(47, 0);
      shd[k] = $urandom;
      dly <= 4'($urandom_range(5, 0));
      acc(1'b1, 9'(9'h140 + 4 * k), 4'hf, shd[k], 0, 0);
      acc(1'b0, 9'(9'h140 + 4 * k), 4'hf, 0, shd[k], 0);
    end
    $display("operational test done");
    // reset in mid-run clears the scratch word
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    acc(1'b0, 9'h000, 4'hf, 0, 0, 0);
    chk_rd("scratch", 32'h0, scr);
    $display("reset test done");
    final_report();
  end
endmodule

bind uhcr_regs uhcr_regs_props #(
  .PORT_INDICATOR_OPT(PORT_INDICATOR_OPT), .PORT_POWER_OPT(PORT_POWER_OPT),
  .VERSION_MAJOR(VERSION_MAJOR), .VERSION_MINOR(VERSION_MINOR)
) uhcr_regs_props_inst (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req_in),
  .wr_in(wr_in), .addr_in(addr_in), .ack_out(ack_out),
  .rdata_out(rdata_out), .busy_out(busy_out), .op_req_out(op_req_out),
  .op_addr_out(op_addr_out), .op_ack_in(op_ack_in));
